// [orn_overrange_preset.v]
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
`include "orn_defs.vh"

module orn_overrange_preset #(
    parameter SAMPLE_W = 16,
    parameter ADDR_W = 14
)(
    // clock and reset
    input wire ref_clk,
    input wire srst,
    // avalon-mm slave, byte address
    input wire [ADDR_W-1:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWritedata,
    input wire [3:0] avsByteenable,
    output reg [31:0] avsReaddata,
    output reg avsWaitrequest,
    // ddc output samples
    input wire signed [SAMPLE_W-1:0] ddcAI,
    input wire signed [SAMPLE_W-1:0] ddcAQ,
    input wire ddcAValid,
    input wire signed [SAMPLE_W-1:0] ddcBI,
    input wire signed [SAMPLE_W-1:0] ddcBQ,
    input wire ddcBValid,
    // control bits toward the serial link
    output reg [1:0] linkOvrA,
    output reg [1:0] linkOvrB,
    // over-range flag pins
    output reg chanAFlagLo,
    output reg chanAFlagHi,
    output reg chanBFlagLo,
    output reg chanBFlagHi,
    // preset selection pins
    input wire [1:0] presetPinsA,
    input wire [1:0] presetPinsB,
    // active preset indices toward the nco
    output reg [1:0] presetIdxA,
    output reg [1:0] presetIdxB,
    // channel binding toward the datapath
    output reg [1:0] channelBinding,
    // interrupt
    output reg irq
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] iThr_q;
reg [7:0] qThr_q;
reg flagPinEnable_q;
reg [2:0] stretchExp_q;
reg [1:0] sourceMode_q;
reg [1:0] presetIndexA_q;
reg [1:0] presetIndexB_q;
reg [1:0] bind_q;
reg singleChan_q;
reg [3:0] irqStat_q;
reg [3:0] irqMask_q;
reg [3:0] irqStat_d;

wire [11:0] regIdx;
wire busReq;
wire doWrite;
wire lane0;

assign regIdx = avsAddress[13:2];
assign busReq = avsRead | avsWrite;
// the write lands at the edge where waitrequest is sampled low
assign doWrite = avsWrite & ~avsWaitrequest;
assign lane0 = avsByteenable[0];

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
reg [1:0] pinsAMeta_q;
reg [1:0] pinsASync_q;
reg [1:0] pinsBMeta_q;
reg [1:0] pinsBSync_q;

always @(posedge ref_clk)
begin
    if (srst)
    begin
        pinsAMeta_q <= 2'h0;
        pinsASync_q <= 2'h0;
        pinsBMeta_q <= 2'h0;
        pinsBSync_q <= 2'h0;
    end
    else
    begin
        pinsAMeta_q <= presetPinsA;
        pinsASync_q <= pinsAMeta_q;
        pinsBMeta_q <= presetPinsB;
        pinsBSync_q <= pinsBMeta_q;
    end
end

// ----------------------------------------
// over-range detection and stretch
// ----------------------------------------
wire [SAMPLE_W-1:0] smp [0:3];
wire [3:0] smpValid;
wire [3:0] hit;
wire [3:0] flagOn;
wire [10:0] stretchLen;

assign smp[0] = ddcAI;
assign smp[1] = ddcAQ;
assign smp[2] = ddcBI;
assign smp[3] = ddcBQ;
assign smpValid = {ddcBValid, ddcBValid, ddcAValid, ddcAValid};
assign stretchLen = `ORN_STRETCH_BASE << stretchExp_q;

genvar k;
generate
    for (k = 0; k < 4; k = k + 1)
    begin : g_pin
        wire [SAMPLE_W-1:0] absV;
        wire [7:0] thr;
        wire [SAMPLE_W+7:0] lhs;
        wire [SAMPLE_W+7:0] rhs;
        reg [10:0] cnt_q;
        reg [10:0] cnt_d;

        // most negative sample still gives the right unsigned magnitude
        assign absV = smp[k][SAMPLE_W-1] ? (~smp[k] + {{(SAMPLE_W-1){1'b0}}, 1'b1}) : smp[k];
        assign thr = (k % 2 == 1) ? qThr_q : iThr_q;
        // |s|/2^(W-1) >= thr/256, cross-multiplied
        assign lhs = {absV, 8'h00};
        assign rhs = {1'b0, thr, {(SAMPLE_W-1){1'b0}}};
        assign hit[k] = smpValid[k] & (lhs >= rhs);

        always @*
        begin
            cnt_d = cnt_q;
            if (hit[k])
                cnt_d = stretchLen;
            else if (cnt_q != 11'h000)
                cnt_d = cnt_q - 11'h001;
        end

        always @(posedge ref_clk)
        begin
            if (srst)
                cnt_q <= 11'h000;
            else
                cnt_q <= cnt_d;
        end

        // high for stretchLen cycles after the last hit
        assign flagOn[k] = flagPinEnable_q & (cnt_d != 11'h000);
    end
endgenerate

always @(posedge ref_clk)
begin
    if (srst)
    begin
        linkOvrA <= 2'h0;
        linkOvrB <= 2'h0;
        chanAFlagLo <= 1'b0;
        chanAFlagHi <= 1'b0;
        chanBFlagLo <= 1'b0;
        chanBFlagHi <= 1'b0;
    end
    else
    begin
        // link bits carry the raw detection, never gated
        linkOvrA <= hit[1:0];
        linkOvrB <= hit[3:2];
        chanAFlagLo <= flagOn[0];
        chanAFlagHi <= flagOn[1];
        chanBFlagLo <= flagOn[2];
        chanBFlagHi <= flagOn[3];
    end
end

// ----------------------------------------
// preset selection
// ----------------------------------------
reg [1:0] selA;
reg [1:0] selB;

always @*
begin
    case (sourceMode_q)
        `ORN_MODE_PINS_AB:
        begin
            selA = pinsASync_q;
            selB = pinsBSync_q;
        end
        `ORN_MODE_PINS_A:
        begin
            selA = pinsASync_q;
            selB = pinsASync_q;
        end
        default:
        begin
            // reserved mode 3 falls back to register selection
            selA = presetIndexA_q;
            selB = presetIndexB_q;
        end
    endcase
    if (singleChan_q)
        selB = selA;
end

always @(posedge ref_clk)
begin
    if (srst)
    begin
        presetIdxA <= 2'h0;
        presetIdxB <= 2'h0;
    end
    else
    begin
        presetIdxA <= selA;
        presetIdxB <= selB;
    end
end

// ----------------------------------------
// register writes
// ----------------------------------------
always @*
begin
    irqStat_d = irqStat_q;
    if (doWrite && lane0 && regIdx == `ORN_IDX_IRQ_STAT)
        irqStat_d = irqStat_q & ~avsWritedata[3:0];
    // a hit in the clearing cycle wins
    irqStat_d = irqStat_d | hit;
end

always @(posedge ref_clk)
begin
    if (srst)
    begin
        iThr_q <= `ORN_RST_I_THR;
        qThr_q <= `ORN_RST_Q_THR;
        flagPinEnable_q <= 1'b0;
        stretchExp_q <= `ORN_RST_STRETCH;
        sourceMode_q <= `ORN_MODE_REG;
        presetIndexA_q <= 2'h0;
        presetIndexB_q <= 2'h0;
        bind_q <= `ORN_RST_BIND;
        singleChan_q <= 1'b0;
        irqStat_q <= 4'h0;
        irqMask_q <= 4'h0;
    end
    else
    begin
        irqStat_q <= irqStat_d;
        if (doWrite && lane0)
        begin
            if (regIdx == `ORN_IDX_I_THR)
                iThr_q <= avsWritedata[7:0];
            else if (regIdx == `ORN_IDX_Q_THR)
                qThr_q <= avsWritedata[7:0];
            else if (regIdx == `ORN_IDX_CFG)
            begin
                flagPinEnable_q <= avsWritedata[`ORN_CFG_EN_BIT];
                stretchExp_q <= avsWritedata[`ORN_CFG_N_MSB:0];
            end
            else if (regIdx == `ORN_IDX_MODE)
                sourceMode_q <= avsWritedata[1:0];
            else if (regIdx == `ORN_IDX_SEL)
            begin
                presetIndexA_q <= avsWritedata[`ORN_SEL_A_MSB:0];
                presetIndexB_q <= avsWritedata[`ORN_SEL_B_MSB:`ORN_SEL_B_LSB];
            end
            else if (regIdx == `ORN_IDX_BIND)
                bind_q <= avsWritedata[1:0];
            else if (regIdx == `ORN_IDX_IRQ_MASK)
                irqMask_q <= avsWritedata[3:0];
            else if (regIdx == `ORN_IDX_CHAN_MODE)
                singleChan_q <= avsWritedata[0];
        end
    end
end

// ----------------------------------------
// read data, waitrequest, interrupt
// ----------------------------------------
reg [7:0] rdMux;

always @*
begin
    if (regIdx == `ORN_IDX_I_THR)
        rdMux = iThr_q;
    else if (regIdx == `ORN_IDX_Q_THR)
        rdMux = qThr_q;
    else if (regIdx == `ORN_IDX_CFG)
        rdMux = {4'h0, flagPinEnable_q, stretchExp_q};
    else if (regIdx == `ORN_IDX_MODE)
        rdMux = {6'h00, sourceMode_q};
    else if (regIdx == `ORN_IDX_SEL)
        rdMux = {4'h0, presetIndexB_q, presetIndexA_q};
    else if (regIdx == `ORN_IDX_BIND)
        rdMux = {6'h00, bind_q};
    else if (regIdx == `ORN_IDX_IRQ_STAT)
        rdMux = {4'h0, irqStat_q};
    else if (regIdx == `ORN_IDX_IRQ_MASK)
        rdMux = {4'h0, irqMask_q};
    else if (regIdx == `ORN_IDX_CHAN_MODE)
        rdMux = {7'h00, singleChan_q};
    else if (regIdx == `ORN_IDX_ACTIVE)
        rdMux = {4'h0, presetIdxB, presetIdxA};
    else
        rdMux = 8'h00;
end

always @(posedge ref_clk)
begin
    if (srst)
    begin
        avsWaitrequest <= 1'b1;
        avsReaddata <= 32'h00000000;
        irq <= 1'b0;
        channelBinding <= `ORN_RST_BIND;
    end
    else
    begin
        // one wait cycle per access, then back to busy
        avsWaitrequest <= ~(busReq & avsWaitrequest);
        if (avsRead && avsWaitrequest)
            avsReaddata <= {24'h000000, rdMux};
        irq <= |(irqStat_d & irqMask_q);
        channelBinding <= bind_q;
    end
end

endmodule // orn_overrange_preset

// [orn_defs.vh]
`ifndef ORN_DEFS_VH
`define ORN_DEFS_VH

// register indices; byte address is four times the index
`define ORN_IDX_I_THR 12'h211
`define ORN_IDX_Q_THR 12'h212
`define ORN_IDX_CFG 12'h213
`define ORN_IDX_MODE 12'h214
`define ORN_IDX_SEL 12'h215
`define ORN_IDX_BIND 12'h216
`define ORN_IDX_IRQ_STAT 12'h220
`define ORN_IDX_IRQ_MASK 12'h221
`define ORN_IDX_CHAN_MODE 12'h222
`define ORN_IDX_ACTIVE 12'h223

// reset values
`define ORN_RST_I_THR 8'hF2
`define ORN_RST_Q_THR 8'hAB
`define ORN_RST_STRETCH 3'h7
`define ORN_RST_BIND 2'h2

// field positions
`define ORN_CFG_EN_BIT 3
`define ORN_CFG_N_MSB 2
`define ORN_SEL_A_MSB 1
`define ORN_SEL_B_LSB 2
`define ORN_SEL_B_MSB 3

// preset source modes
`define ORN_MODE_REG 2'h0
`define ORN_MODE_PINS_AB 2'h1
`define ORN_MODE_PINS_A 2'h2

// timing: base stretch in device clock cycles, threshold denominator bits
`define ORN_STRETCH_BASE 11'h008
`define ORN_THR_FRAC_BITS 8

`endif

// [orn_properties.sv]
`timescale 1ns/10ps
// ----
// port checks
// ----
module orn_properties #(
    parameter SAMPLE_W = 16,
    parameter ADDR_W = 14
)(
    // clock and reset
    input wire ref_clk,
    input wire srst,
    // register bus
    input wire [ADDR_W-1:0] avsAddress,
    input wire avsWrite,
    input wire [31:0] avsWritedata,
    input wire avsWaitrequest,
    // samples and outputs
    input wire signed [SAMPLE_W-1:0] ddcAI,
    input wire signed [SAMPLE_W-1:0] ddcAQ,
    input wire ddcAValid,
    input wire [1:0] linkOvrA,
    input wire chanAFlagLo,
    input wire chanAFlagHi,
    input wire [1:0] presetIdxA,
    input wire [1:0] presetIdxB
);
    // full scale beats any threshold below 256
    localparam logic signed [SAMPLE_W-1:0] FS = {1'b0, {(SAMPLE_W-1){1'b1}}};
    reg [7:0] cfg_q;
    reg [1:0] mode_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            cfg_q <= 8'h07;
            mode_q <= 2'h0;
        end
        else if (avsWrite && !avsWaitrequest)
        begin
            if (avsAddress == 14'h084C) cfg_q <= avsWritedata[7:0];
            if (avsAddress == 14'h0850) mode_q <= avsWritedata[1:0];
        end
    end
    sequence sPinsOff;
        !cfg_q[3] [*2];
    endsequence
    AST_Q_HIT: assert property (ddcAValid && ddcAQ == FS |=> linkOvrA[1])
        else $error("q full scale not flagged");
    AST_I_HIT: assert property (ddcAValid && ddcAI == FS |=> linkOvrA[0])
        else $error("i full scale not flagged");
    AST_NO_VALID: assert property (!ddcAValid |=> linkOvrA == 2'h0)
        else $error("link bit without valid sample");
    AST_STRETCH: assert property ($rose(chanAFlagHi) |-> (chanAFlagHi || !cfg_q[3]) [*8])
        else $error("flag pulse too short");
    AST_HI_SRC: assert property ($rose(chanAFlagHi) && $past(cfg_q[3]) |-> linkOvrA[1])
        else $error("upper flag without q hit");
    AST_LO_SRC: assert property ($rose(chanAFlagLo) && $past(cfg_q[3]) |-> linkOvrA[0])
        else $error("lower flag without i hit");
    AST_PIN_GATE: assert property (sPinsOff |-> !chanAFlagLo && !chanAFlagHi)
        else $error("flag pin high while disabled");
    AST_SHARED: assert property ((mode_q == 2'h2) [*4] |-> presetIdxA == presetIdxB)
        else $error("shared pin mode gives two presets");
endmodule // orn_properties

// [orn_host_model.sv]
`timescale 1ns/10ps
// ----
// host: preset pins, flag timing
// ----
module orn_host_model (
    // clock
    input wire logic ref_clk,
    // wanted pin values
    input wire logic [1:0] wantA,
    input wire logic [1:0] wantB,
    // pins and flag
    output logic [1:0] presetPinsA = 2'h0,
    output logic [1:0] presetPinsB = 2'h0,
    input wire logic chanAFlagHi,
    output int hiLen = 0
);
    int run = 0;
    always @(posedge ref_clk)
    begin
        presetPinsA <= wantA;
        presetPinsB <= wantB;
        run <= chanAFlagHi ? run + 1 : 0;
        if (!chanAFlagHi && run != 0)
            hiLen <= run;
    end
endmodule // orn_host_model

// [orn_testbench.sv]
`timescale 1ns/10ps
module testbench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [13:0] avsAddress = 14'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic signed [15:0] ddcAI = 16'h0;
    logic signed [15:0] ddcAQ = 16'h0;
    logic ddcAValid = 1'b0;
    logic signed [15:0] ddcBI = 16'h0;
    logic signed [15:0] ddcBQ = 16'h0;
    logic ddcBValid = 1'b0;
    logic [1:0] wantA = 2'h0;
    logic [1:0] wantB = 2'h0;
    logic [31:0] avsReaddata, rdData;
    logic [1:0] linkOvrA, linkOvrB, presetIdxA, presetIdxB, channelBinding, presetPinsA, presetPinsB;
    logic avsWaitrequest, chanAFlagLo, chanAFlagHi, chanBFlagLo, chanBFlagHi, irq;
    int hiLen;
    int bad_count = 0;
    int cmp_count = 0;
    orn_overrange_preset i_dut (.ref_clk, .srst, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
        .avsByteenable(4'hF), .avsReaddata, .avsWaitrequest, .ddcAI, .ddcAQ, .ddcAValid,
        .ddcBI, .ddcBQ, .ddcBValid, .linkOvrA, .linkOvrB, .chanAFlagLo,
        .chanAFlagHi, .chanBFlagLo, .chanBFlagHi, .presetPinsA, .presetPinsB, .presetIdxA,
        .presetIdxB, .channelBinding, .irq);
    orn_host_model i_host (.ref_clk, .wantA, .wantB, .presetPinsA, .presetPinsB, .chanAFlagHi, .hiLen);
    initial
        forever #25 ref_clk = ~ref_clk;
    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [11:0] i, input logic [7:0] d, input logic wr = 1'b1);
        @(posedge ref_clk);
        avsAddress <= {i, 2'b00};
        avsWritedata <= {24'h0, d};
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge ref_clk);
        while (avsWaitrequest)
            @(posedge ref_clk);
        rdData = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] i, input logic [7:0] e);
        acc(i, 8'h00, 1'b0);
        chk(rdData, {24'h0, e});
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic smp(input logic signed [15:0] i, input logic signed [15:0] q);
        @(posedge ref_clk);
        ddcAI <= i;
        ddcAQ <= q;
        ddcAValid <= 1'b1;
        @(posedge ref_clk);
        ddcAValid <= 1'b0;
        #1;
    endtask
    task automatic smpB(input logic signed [15:0] i, input logic signed [15:0] q);
        @(posedge ref_clk);
        ddcBI <= i;
        ddcBQ <= q;
        ddcBValid <= 1'b1;
        @(posedge ref_clk);
        ddcBValid <= 1'b0;
        #1;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        logic [11:0] idx [7] = '{12'h211, 12'h212, 12'h213, 12'h214, 12'h215, 12'h216, 12'h300};
        logic [7:0] val [7] = '{8'hF2, 8'hAB, 8'h07, 8'h00, 8'h00, 8'h02, 8'h00};
        for (int k = 0; k < 7; k++)
            rc(idx[k], val[k]);
        w(1);
        chk({channelBinding, presetIdxB, presetIdxA, avsWaitrequest, irq}, 8'h82);
        $display("reset done");
    endtask
    task automatic t_sel;
        acc(12'h213, 8'hFF);
        rc(12'h213, 8'h0F);
        for (int k = 0; k < 4; k++)
        begin
            acc(12'h215, {4'h0, 2'(3 - k), 2'(k)});
            w(2);
            chk(presetIdxA, k);
            chk(presetIdxB, 3 - k);
        end
        acc(12'h216, 8'h01);
        w(2);
        chk(channelBinding, 2'h1);
        $display("select done");
    endtask
    task automatic t_hit;
        acc(12'h212, 8'h80);
        acc(12'h221, 8'h02);
        for (int n = 0; n < 2; n++)
        begin
            acc(12'h213, 8'(8 + n));
            smp(16'h0, 16'h3FFF);
            chk(linkOvrA, 2'h0);
            smp(16'h0, 16'hC000);
            chk(linkOvrA, 2'h2);
            chk(chanAFlagHi, 1'b1);
            chk(irq, 1'b1);
            w(20);
            chk(hiLen, 8 << n);
        end
        acc(12'h221, 8'h00);
        w(1);
        chk(irq, 1'b0);
        rc(12'h220, 8'h02);
        acc(12'h220, 8'h02);
        rc(12'h220, 8'h00);
        $display("hit done");
    endtask
    task automatic t_gate;
        acc(12'h213, 8'h08);
        smp(16'h7FFF, 16'h0);
        chk(chanAFlagLo, 1'b1);
        chk(chanAFlagHi, 1'b0);
        w(12);
        acc(12'h213, 8'h00);
        smp(16'h7FFF, 16'h7FFF);
        chk(linkOvrA, 2'h3);
        chk(chanAFlagLo, 1'b0);
        chk(chanAFlagHi, 1'b0);
        $display("gate done");
    endtask
    task automatic t_chb;
        acc(12'h220, 8'h0F);
        acc(12'h211, 8'h40);
        acc(12'h213, 8'h08);
        smpB(16'h2000, 16'h8000);
        chk(linkOvrB, 2'h3);
        chk({chanBFlagHi, chanBFlagLo}, 2'h3);
        chk(linkOvrA, 2'h0);
        smpB(16'h1FFF, 16'h0);
        chk(linkOvrB, 2'h0);
        rc(12'h220, 8'h0C);
        acc(12'h220, 8'h04);
        rc(12'h220, 8'h08);
        $display("channel b done");
    endtask
    task automatic t_pins;
        @(posedge ref_clk);
        wantA <= 2'h1;
        wantB <= 2'h3;
        acc(12'h214, 8'h01);
        w(6);
        chk(presetIdxA, 2'h1);
        chk(presetIdxB, 2'h3);
        acc(12'h214, 8'h02);
        w(2);
        chk(presetIdxB, 2'h1);
        acc(12'h214, 8'h00);
        acc(12'h215, 8'h06);
        acc(12'h222, 8'h01);
        w(2);
        chk(presetIdxB, 2'h2);
        acc(12'h214, 8'h01);
        w(2);
        chk(presetIdxB, 2'h1);
        rc(12'h223, 8'h05);
        $display("pins done");
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset;
        t_sel;
        t_hit;
        t_gate;
        t_chb;
        t_pins;
        stop_test;
    end
    // whole run is well under 1000 cycles
    initial
    begin
        #100us;
        bad_count++;
        stop_test;
    end
endmodule // testbench
bind orn_overrange_preset orn_properties #(.SAMPLE_W(SAMPLE_W), .ADDR_W(ADDR_W)) i_props (.ref_clk,
    .srst, .avsAddress, .avsWrite, .avsWritedata, .avsWaitrequest, .ddcAI, .ddcAQ, .ddcAValid,
    .linkOvrA, .chanAFlagLo, .chanAFlagHi, .presetIdxA, .presetIdxB);
